/* logic/scc_attr_decode.sv */
// memory-type override decoder and merge with upstream attributes
`timescale 1ns/100ps
module scc_attr_decode
  import scc_pkg::*;
(
  // override field and switches
  input wire logic [3:0] memory_type_override,
  input wire logic xlat_enable,
  // upstream attributes
  input wire logic [3:0] upstream_attr,
  // merged result
  output logic [3:0] merged_attr,
  output logic attr_reserved
);
  wire logic [1:0] outer_sel;
  wire logic [1:0] inner_sel;
  wire logic is_dev_class;
  wire logic [3:0] weaker;
  assign outer_sel = memory_type_override[3:2];
  assign inner_sel = memory_type_override[1:0];
  assign is_dev_class = (outer_sel == SCC_OUT_DEVICE);
  // device: only 00/01 legal; normal: inner 00 illegal
  assign attr_reserved = is_dev_class ? inner_sel[1] : (inner_sel == 2'h0);
  // combine by taking the weaker (lower) class per half so the earlier step is never strengthened
  assign weaker[3:2] = (outer_sel < upstream_attr[3:2]) ? outer_sel : upstream_attr[3:2];
  assign weaker[1:0] = (weaker[3:2] == SCC_OUT_DEVICE) ?
                       ((upstream_attr[3:2] == SCC_OUT_DEVICE && outer_sel == SCC_OUT_DEVICE &&
                         inner_sel < upstream_attr[1:0]) ? inner_sel :
                        (upstream_attr[3:2] == SCC_OUT_DEVICE ? upstream_attr[1:0] : inner_sel)) :
                       ((inner_sel < upstream_attr[1:0]) ? inner_sel : upstream_attr[1:0]);
  // override only applies with translation off; reserved codes leave upstream untouched
  assign merged_attr = (!xlat_enable && !attr_reserved) ? weaker : upstream_attr;
endmodule // scc_attr_decode

/* logic/scc_context_ctrl.sv */
// stage-2 context control: registers, fault handling and walk policy
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - upper override bits pick outer memory class
// - lower override bits pick device or inner class
// - override only merges while translation disabled
// - barrier field sets minimum barrier shareability
// - without upgrade support barrier field reads zero
// - walk guard faults device-typed first-stage walks
// - hit-past-fault zero blocks later transactions
// - no strict fault ordering across clients
// - stall select chooses stall or terminate
// - interrupt only with enable; enable resets zero
// - abort response only when abort enabled
// - endian bit picks table entry byte order
// - clear access flag faults unless disabled
// - disabled access fault treats flag as set
// - flag and remap bits write as one
// - enable bit switches translation on or off
// - bits twelve to nine write as zero
// - long format flag reads one always
// - walk shareability and cacheability fields output
// - start level two or three is illegal
// - region spans two to thirty-two minus offset
// - lowest base bit from level and offset
module scc_context_ctrl
  import scc_pkg::*;
#(
  parameter bit HAS_BARRIER_RAISE = 1'b1,
  parameter bit HAS_NESTED = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // transaction check request (same clock)
  input wire logic txn_valid,
  input wire logic [3:0] txn_attr,
  input wire logic txn_is_walk,
  input wire logic txn_walk_dev,
  input wire logic [1:0] txn_barrier_sh,
  input wire logic txn_barrier,
  input wire logic [7:0] entry_byte0,
  input wire logic [7:0] entry_byte_last,
  input wire logic entry_valid,
  input wire logic fault_clear,
  // transaction answer
  output logic txn_pass,
  output logic txn_stall,
  output logic txn_abort,
  output logic txn_blocked,
  output logic [3:0] txn_attr_out,
  output logic [1:0] barrier_sh_out,
  output logic fault_irq,
  output logic access_flag_fault,
  output logic guard_fault,
  output logic endian_big,
  output logic xlat_on,
  // walk attributes
  output logic [1:0] walk_shareability,
  output logic [1:0] walk_outer_cacheability,
  output logic [1:0] walk_inner_cacheability
);
  logic [31:0] sys_ctrl;
  logic [31:0] tbl_ctrl;
  logic fault_pend;
  logic [7:0] fault_count;
  scc_fstate_t fstate;
  scc_fstate_t next_fstate;

  // writable mask depends on what the implementation supports
  wire logic [31:0] sys_wmask;
  assign sys_wmask = SCC_SYS_WMASK_BASE | (HAS_BARRIER_RAISE ? SCC_SYS_WMASK_BARRIER : 32'h0) |
                     (HAS_NESTED ? SCC_SYS_WMASK_GUARD : 32'h0);

  // register decode
  wire logic hit_sys;
  wire logic hit_tbl;
  wire logic hit_status;
  wire logic hit_derived;
  assign hit_sys = (reg_addr == SCC_OFF_SYS_CTRL);
  assign hit_tbl = (reg_addr == SCC_OFF_TBL_CTRL);
  assign hit_status = (reg_addr == SCC_OFF_STATUS);
  assign hit_derived = (reg_addr == SCC_OFF_DERIVED);

  // field views
  wire logic [3:0] memory_type_override;
  wire logic [1:0] barrier_domain_raise;
  wire logic walk_device_guard;
  wire logic hit_past_fault;
  wire logic fault_stall_select;
  wire logic fault_irq_enable;
  wire logic fault_abort_enable;
  wire logic table_big_endian;
  wire logic access_flag_fault_off;
  wire logic xlat_enable;
  assign memory_type_override = sys_ctrl[SCC_MEMTYPE_LSB +: 4];
  assign barrier_domain_raise = sys_ctrl[SCC_BARRIER_LSB +: 2];
  assign walk_device_guard = sys_ctrl[SCC_WALK_GUARD_BIT];
  assign hit_past_fault = sys_ctrl[SCC_HIT_PAST_BIT];
  assign fault_stall_select = sys_ctrl[SCC_STALL_SEL_BIT];
  assign fault_irq_enable = sys_ctrl[SCC_IRQ_EN_BIT];
  assign fault_abort_enable = sys_ctrl[SCC_ABORT_EN_BIT];
  assign table_big_endian = sys_ctrl[SCC_ENDIAN_BIT];
  assign access_flag_fault_off = sys_ctrl[SCC_AF_OFF_BIT];
  assign xlat_enable = sys_ctrl[SCC_XLAT_EN_BIT];

  wire logic [1:0] walk_start_level;
  wire logic [3:0] region_size_offset;
  assign walk_start_level = tbl_ctrl[SCC_START_LVL_LSB +: 2];
  assign region_size_offset = tbl_ctrl[SCC_SIZE_OFF_LSB +: 4];

  // attribute merge and size helpers
  wire logic [3:0] merged_attr;
  wire logic attr_reserved;
  wire logic [6:0] region_log2;
  wire logic [6:0] base_low_bit;
  wire logic level_illegal;
  scc_attr_decode u_attr (
    .memory_type_override(memory_type_override),
    .xlat_enable(xlat_enable),
    .upstream_attr(txn_attr),
    .merged_attr(merged_attr),
    .attr_reserved(attr_reserved)
  );
  scc_size_calc u_size (
    .region_size_offset(region_size_offset),
    .walk_start_level(walk_start_level),
    .region_log2(region_log2),
    .base_low_bit(base_low_bit),
    .level_illegal(level_illegal)
  );

  // access flag: endian bit chooses which byte holds the low descriptor bits
  wire logic [7:0] entry_low;
  wire logic entry_access_flag;
  wire logic af_fault_now;
  assign entry_low = table_big_endian ? entry_byte_last : entry_byte0;
  assign entry_access_flag = access_flag_fault_off ? 1'b1 : entry_low[0];
  assign af_fault_now = txn_valid && xlat_enable && entry_valid && !entry_access_flag;

  // walk to device memory with the guard on becomes a permission fault
  wire logic guard_now;
  assign guard_now = txn_valid && xlat_enable && HAS_NESTED && walk_device_guard && txn_is_walk &&
                     txn_walk_dev;
  wire logic fault_now;
  assign fault_now = af_fault_now || guard_now;

  // later traffic held while a fault is outstanding unless hit-past is set;
  // other clients may slip through before this takes effect, no ordering promised
  wire logic block_now;
  assign block_now = txn_valid && fault_pend && !hit_past_fault && !fault_now;

  // barrier shareability floor
  wire logic [1:0] barrier_floor;
  assign barrier_floor = (barrier_domain_raise > txn_barrier_sh) ? barrier_domain_raise :
                         txn_barrier_sh;

  // fault state machine
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      SCC_F_IDLE: begin
        if (fault_now) begin
          next_fstate = fault_stall_select ? SCC_F_STALL : SCC_F_TERM;
        end
      end
      // a fresh fault in the clearing cycle wins, so state agrees with the pending flag
      SCC_F_STALL, SCC_F_TERM: begin
        if (fault_now) begin
          next_fstate = fault_stall_select ? SCC_F_STALL : SCC_F_TERM;
        end else if (fault_clear) begin
          next_fstate = SCC_F_IDLE;
        end
      end
      default: next_fstate = SCC_F_IDLE;
    endcase
  end

  // register writes: masked fields, fixed bits, reserved stay zero
  wire logic [31:0] next_sys;
  wire logic [31:0] next_tbl;
  assign next_sys = (reg_wdata & sys_wmask) | SCC_SYS_RESET;
  assign next_tbl = (reg_wdata & SCC_TBL_WMASK) | SCC_TBL_FIXED;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_ctrl <= SCC_SYS_RESET;
      tbl_ctrl <= SCC_TBL_FIXED;
    end else if (reg_write && hit_sys) begin
      sys_ctrl <= next_sys;
    end else if (reg_write && hit_tbl) begin
      tbl_ctrl <= next_tbl;
    end
  end

  // outstanding fault: a new fault wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fstate <= SCC_F_IDLE;
      fault_pend <= 1'b0;
      fault_count <= 8'h00;
    end else begin
      fstate <= next_fstate;
      fault_pend <= fault_now || (fault_pend && !fault_clear);
      fault_count <= fault_now ? 8'(fault_count + 8'h01) : fault_count;
    end
  end

  // read mux
  wire logic [31:0] status_word;
  wire logic [31:0] derived_word;
  wire logic [31:0] rd_mux;
  assign status_word = {24'h0, 1'b0, level_illegal, attr_reserved, fstate, fault_pend, xlat_enable};
  assign derived_word = {fault_count, 1'b0, region_log2, 1'b0, base_low_bit, 4'h0, merged_attr};
  assign rd_mux = hit_sys ? sys_ctrl :
                  hit_tbl ? tbl_ctrl :
                  hit_status ? status_word :
                  hit_derived ? derived_word : 32'h0;

  // answers registered so every output starts from a flip-flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
      txn_pass <= 1'b0;
      txn_stall <= 1'b0;
      txn_abort <= 1'b0;
      txn_blocked <= 1'b0;
      txn_attr_out <= 4'h0;
      barrier_sh_out <= 2'h0;
      fault_irq <= 1'b0;
      access_flag_fault <= 1'b0;
      guard_fault <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 32'h0;
      txn_pass <= txn_valid && !fault_now && !block_now;
      txn_stall <= (fault_now && fault_stall_select) || (block_now && fault_stall_select);
      txn_abort <= fault_now && !fault_stall_select && fault_abort_enable;
      txn_blocked <= block_now;
      txn_attr_out <= merged_attr;
      // a stale barrier flag without a request must not show a domain
      barrier_sh_out <= (txn_valid && txn_barrier) ? barrier_floor : 2'h0;
      fault_irq <= fault_now && fault_irq_enable;
      access_flag_fault <= af_fault_now;
      guard_fault <= guard_now;
    end
  end

  // static control outputs, registered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      endian_big <= 1'b0;
      xlat_on <= 1'b0;
      walk_shareability <= 2'h0;
      walk_outer_cacheability <= 2'h0;
      walk_inner_cacheability <= 2'h0;
    end else begin
      endian_big <= table_big_endian;
      xlat_on <= xlat_enable;
      walk_shareability <= tbl_ctrl[SCC_WALK_SH_LSB +: 2];
      walk_outer_cacheability <= tbl_ctrl[SCC_WALK_OUTER_LSB +: 2];
      walk_inner_cacheability <= tbl_ctrl[SCC_WALK_INNER_LSB +: 2];
    end
  end
endmodule // scc_context_ctrl

/* logic/scc_pkg.sv */
// package: register map, field layout and encodings for the stage-2 context control block
package scc_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] SCC_OFF_SYS_CTRL = 8'h00;
  localparam logic [7:0] SCC_OFF_TBL_CTRL = 8'h04;
  localparam logic [7:0] SCC_OFF_STATUS = 8'h08;
  localparam logic [7:0] SCC_OFF_FAULT_IN = 8'h0c;
  localparam logic [7:0] SCC_OFF_DERIVED = 8'h10;
  // system control field positions
  localparam int SCC_MEMTYPE_LSB = 16;
  localparam int SCC_BARRIER_LSB = 14;
  localparam int SCC_WALK_GUARD_BIT = 13;
  localparam int SCC_HIT_PAST_BIT = 8;
  localparam int SCC_STALL_SEL_BIT = 7;
  localparam int SCC_IRQ_EN_BIT = 6;
  localparam int SCC_ABORT_EN_BIT = 5;
  localparam int SCC_ENDIAN_BIT = 4;
  localparam int SCC_AF_OFF_BIT = 3;
  localparam int SCC_AF_ON_BIT = 2;
  localparam int SCC_REMAP_ON_BIT = 1;
  localparam int SCC_XLAT_EN_BIT = 0;
  // writable masks; reserved bits read zero
  localparam logic [31:0] SCC_SYS_WMASK_BASE = 32'h000f_01fb;
  localparam logic [31:0] SCC_SYS_WMASK_BARRIER = 32'h0000_c000;
  localparam logic [31:0] SCC_SYS_WMASK_GUARD = 32'h0000_2000;
  localparam logic [31:0] SCC_SYS_RESET = 32'h0000_0006;
  localparam logic [31:0] SCC_TBL_WMASK = 32'h0000_3fdf;
  localparam logic [31:0] SCC_TBL_FIXED = 32'h8000_0000;
  localparam logic [31:0] SCC_TBL_RESET = 32'h0000_0000;
  // table control field positions
  localparam int SCC_WALK_SH_LSB = 12;
  localparam int SCC_WALK_OUTER_LSB = 10;
  localparam int SCC_WALK_INNER_LSB = 8;
  localparam int SCC_START_LVL_LSB = 6;
  localparam int SCC_SIGN_EXT_BIT = 4;
  localparam int SCC_SIZE_OFF_LSB = 0;
  // base-bit formula constants
  localparam logic signed [6:0] SCC_BASE_LVL2 = 7'sd14;
  localparam logic signed [6:0] SCC_BASE_LVL1 = 7'sd5;
  localparam logic signed [6:0] SCC_REGION_TOP = 7'sd32;
  // outer memory classes
  typedef enum logic [1:0] {
    SCC_OUT_DEVICE = 2'h0, SCC_OUT_NC = 2'h1, SCC_OUT_WT = 2'h2, SCC_OUT_WB = 2'h3
  } scc_outer_t;
  // fault handling states
  typedef enum logic [2:0] {
    SCC_F_IDLE = 3'h1, SCC_F_STALL = 3'h2, SCC_F_TERM = 3'h4
  } scc_fstate_t;
endpackage

/* logic/scc_size_calc.sv */
// region size and lowest base-address bit from the table control fields
`timescale 1ns/100ps
module scc_size_calc
  import scc_pkg::*;
(
  // table control fields
  input wire logic [3:0] region_size_offset,
  input wire logic [1:0] walk_start_level,
  // derived values
  output logic [6:0] region_log2,
  output logic [6:0] base_low_bit,
  output logic level_illegal
);
  wire logic signed [6:0] size_signed;
  assign size_signed = {{3{region_size_offset[3]}}, region_size_offset};
  assign region_log2 = 7'(SCC_REGION_TOP - size_signed);
  assign base_low_bit = (walk_start_level == 2'h0) ? 7'(SCC_BASE_LVL2 - size_signed) :
                        7'(SCC_BASE_LVL1 - size_signed);
  assign level_illegal = walk_start_level[1];
endmodule // scc_size_calc

/* tb/scc_context_ctrl_sva.sv */
// checker: port-level properties of the stage-2 context control block
`timescale 1ns/100ps
module scc_context_ctrl_sva
  import scc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // transaction side
  input wire logic txn_valid,
  input wire logic txn_barrier,
  input wire logic [1:0] txn_barrier_sh,
  input wire logic txn_pass,
  input wire logic txn_stall,
  input wire logic txn_abort,
  input wire logic txn_blocked,
  input wire logic fault_irq,
  input wire logic access_flag_fault,
  input wire logic guard_fault,
  input wire logic [1:0] barrier_sh_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_long_flag_set: assert property (reg_read && reg_addr == SCC_OFF_TBL_CTRL
    |=> reg_rdata[31:14] == 18'h20000)
    else $error("table control top bits wrong");
  a_sys_fixed_bits: assert property (reg_read && reg_addr == SCC_OFF_SYS_CTRL
    |=> reg_rdata[31:20] == 12'h000 && reg_rdata[12:9] == 4'h0 && reg_rdata[2:1] == 2'h3)
    else $error("system control fixed bits wrong");
  a_unmapped_zero: assert property (reg_read && reg_addr == SCC_OFF_FAULT_IN
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_irq_with_fault: assert property (fault_irq |-> access_flag_fault || guard_fault)
    else $error("interrupt without a fault");
  a_pass_exclusive: assert property (txn_pass |-> !(txn_abort || txn_blocked || txn_stall || guard_fault))
    else $error("pass together with a fault answer");
  a_quiet_idle: assert property (!txn_valid |=> !(txn_pass || fault_irq || access_flag_fault || txn_abort))
    else $error("answer without a request");
  a_barrier_floor: assert property (txn_valid && txn_barrier |=> barrier_sh_out >= $past(txn_barrier_sh))
    else $error("barrier shareability lowered");
  a_barrier_idle: assert property (!(txn_valid && txn_barrier) |=> barrier_sh_out == 2'h0)
    else $error("barrier output without barrier");
endmodule // scc_context_ctrl_sva

/* tb/stage2_context_control_test.sv */
// bench: stage-2 context control against a register and fault model
`timescale 1ns/100ps
module stage2_context_control_test;
  import scc_pkg::*;
  logic sys_clk, arst_n, reg_write, reg_read, txn_valid, txn_is_walk, txn_walk_dev, txn_barrier;
  logic entry_valid, fault_clear;
  logic [3:0] ov;
  bit rsv;
  logic [7:0] reg_addr, entry_byte0, entry_byte_last;
  logic [31:0] reg_wdata, reg_rdata, sys_m, tbl_m;
  logic [3:0] txn_attr, txn_attr_out;
  logic [1:0] txn_barrier_sh, barrier_sh_out, ws, wo, wi;
  logic txn_pass, txn_stall, txn_abort, txn_blocked, fault_irq, access_flag_fault, guard_fault, endian_big, xlat_on;
  int fail_count, tests_run, so, lvl;
  bit pend;
  scc_context_ctrl dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .txn_valid(txn_valid), .txn_attr(txn_attr),
    .txn_is_walk(txn_is_walk), .txn_walk_dev(txn_walk_dev), .txn_barrier_sh(txn_barrier_sh), .txn_barrier(txn_barrier),
    .entry_byte0(entry_byte0), .entry_byte_last(entry_byte_last), .entry_valid(entry_valid), .fault_clear(fault_clear),
    .txn_pass(txn_pass), .txn_stall(txn_stall), .txn_abort(txn_abort), .txn_blocked(txn_blocked),
    .txn_attr_out(txn_attr_out), .barrier_sh_out(barrier_sh_out), .fault_irq(fault_irq),
    .access_flag_fault(access_flag_fault), .guard_fault(guard_fault), .endian_big(endian_big), .xlat_on(xlat_on),
    .walk_shareability(ws), .walk_outer_cacheability(wo), .walk_inner_cacheability(wi));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkt(input string nm, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    if (a == SCC_OFF_SYS_CTRL) sys_m = (d & 32'h000f_e1f9) | 32'h0000_0006;
    if (a == SCC_OFF_TBL_CTRL) tbl_m = (d & 32'h0000_3fdf) | 32'h8000_0000;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(nm, e & m, reg_rdata & m);
  endtask
  // weaker class per half; with one side device, the device side keeps its inner code
  function automatic logic [3:0] attr_model(input logic [3:0] ovr, input logic [3:0] up, input bit on);
    logic [1:0] o, i;
    bit bad;
    bad = (ovr[3:2] == 2'h0) ? ovr[1] : (ovr[1:0] == 2'h0);
    o = (ovr[3:2] < up[3:2]) ? ovr[3:2] : up[3:2];
    if (o != 2'h0) i = (ovr[1:0] < up[1:0]) ? ovr[1:0] : up[1:0];
    else if (ovr[3:2] != 2'h0) i = up[1:0];
    else if (up[3:2] != 2'h0) i = ovr[1:0];
    else i = (ovr[1:0] < up[1:0]) ? ovr[1:0] : up[1:0];
    return (on || bad) ? up : {o, i};
  endfunction
  // flag placed in the byte the endian bit picks, inverse in the other to expose a wrong pick
  task automatic txn(input bit fl, input bit wk, input bit dv, input bit br);
    logic [1:0] bs, be;
    logic [3:0] ua;
    bit af, gf;
    bs = 2'($urandom);
    ua = 4'($urandom);
    @(posedge sys_clk);
    txn_valid <= 1'b1;
    txn_is_walk <= wk;
    txn_walk_dev <= dv;
    txn_barrier <= br;
    txn_barrier_sh <= bs;
    txn_attr <= ua;
    entry_byte0 <= {7'h2a, sys_m[4] ? ~fl : fl};
    entry_byte_last <= {7'h15, sys_m[4] ? fl : ~fl};
    @(posedge sys_clk);
    txn_valid <= 1'b0;
    #1;
    af = sys_m[0] && !sys_m[3] && !fl;
    gf = sys_m[0] && sys_m[13] && wk && dv;
    be = !br ? 2'h0 : (bs > sys_m[15:14] ? bs : sys_m[15:14]);
    chkt("barrier", {2'h0, be}, {2'h0, barrier_sh_out});
    chkt("flags", {af, gf, sys_m[4], sys_m[0]},
      {access_flag_fault, guard_fault, endian_big, xlat_on});
    chkt("attr", attr_model(sys_m[19:16], ua, sys_m[0]), txn_attr_out);
    if (af || gf) begin
      // a stalled fault waits for software, so no abort goes back yet
      chkt("fault", {sys_m[7:6], sys_m[5] && !sys_m[7], 1'b0},
        {txn_stall, fault_irq, txn_abort, txn_pass});
      pend = 1'b1;
    end else if (pend && !sys_m[8]) begin
      chkt("blocked", {1'b0, sys_m[7], 2'h2}, {1'b0, txn_stall, txn_blocked, txn_pass});
    end else begin
      chkt("pass", 4'h1, {1'b0, txn_stall, txn_blocked, txn_pass});
    end
  endtask
  task automatic clr();
    @(posedge sys_clk);
    fault_clear <= 1'b1;
    @(posedge sys_clk);
    fault_clear <= 1'b0;
    pend = 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {arst_n, reg_write, reg_read, txn_valid, txn_is_walk, txn_walk_dev, txn_barrier, fault_clear} = '0;
    {reg_addr, reg_wdata, txn_attr, txn_barrier_sh, entry_byte0, entry_byte_last} = '0;
    entry_valid = 1'b1;
    fail_count = 0;
    tests_run = 0;
    pend = 1'b0;
    sys_m = 32'h0000_0006;
    tbl_m = 32'h8000_0000;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    void'($urandom(32'h0fe0));
    rd(SCC_OFF_SYS_CTRL, 32'h0000_0040, 32'h0000_0000, "irq_en_reset");
    rd(SCC_OFF_TBL_CTRL, '1, 32'h8000_0000, "tbl_reset");
    wr(SCC_OFF_SYS_CTRL, '1);
    wr(SCC_OFF_FAULT_IN, '1);
    rd(SCC_OFF_SYS_CTRL, '1, sys_m, "sys_mask");
    wr(SCC_OFF_TBL_CTRL, '1);
    rd(SCC_OFF_TBL_CTRL, '1, tbl_m, "tbl_mask");
    rd(SCC_OFF_FAULT_IN, '1, '0, "unmapped");
    repeat (6) begin
      so = $urandom_range(15);
      lvl = $urandom_range(1);
      wr(SCC_OFF_TBL_CTRL, {18'h0, 6'($urandom), 2'(lvl), 1'b0, so[3], so[3:0]});
      if (so > 7) so -= 16;
      rd(SCC_OFF_DERIVED, 32'h007f_7f00, {9'h0, 7'(32 - so), 1'b0, 7'((lvl ? 5 : 14) - so), 8'h0},
        "size");
      chk("walk_attr", {26'h0, tbl_m[13:8]}, {26'h0, ws, wo, wi});
    end
    wr(SCC_OFF_TBL_CTRL, 32'h0000_0080);
    rd(SCC_OFF_STATUS, 32'h0000_0040, 32'h0000_0040, "level_illegal");
    // every stall, interrupt and abort combination, endian toggling with bit one
    for (int i = 0; i < 8; i++) begin
      wr(SCC_OFF_SYS_CTRL, 32'((i << 5) | ((i & 2) << 3) | 1));
      txn(1'b0, 1'b0, 1'b0, 1'b0);
      txn(1'b1, 1'b0, 1'b0, 1'b0);
      clr();
      txn(1'b1, 1'b0, 1'b0, 1'b0);
    end
    wr(SCC_OFF_SYS_CTRL, 32'h0000_0121);
    txn(1'b0, 1'b0, 1'b0, 1'b0);
    txn(1'b1, 1'b0, 1'b0, 1'b0);
    clr();
    wr(SCC_OFF_SYS_CTRL, 32'h0000_0009);
    txn(1'b0, 1'b0, 1'b0, 1'b0);
    wr(SCC_OFF_SYS_CTRL, 32'h0000_2001);
    txn(1'b1, 1'b1, 1'b1, 1'b0);
    clr();
    txn(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (8) begin
      wr(SCC_OFF_SYS_CTRL, 32'($urandom_range(3) << 14) | 32'h0000_0001);
      txn(1'b1, 1'b0, 1'b0, 1'b1);
    end
    wr(SCC_OFF_SYS_CTRL, 32'h0000_0000);
    txn(1'b0, 1'b0, 1'b0, 1'b0);
    // translation off: random override codes; reserved ones leave the attributes alone
    repeat (12) begin
      ov = 4'($urandom);
      rsv = (ov[3:2] == 2'h0) ? ov[1] : (ov[1:0] == 2'h0);
      wr(SCC_OFF_SYS_CTRL, {12'h0, ov, 16'h0000});
      txn(1'b0, 1'b0, 1'b0, 1'b0);
      rd(SCC_OFF_STATUS, 32'h0000_0020, {26'h0, rsv, 5'h0}, "attr_rsv");
    end
    complete_run();
  end
  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule // stage2_context_control_test
bind scc_context_ctrl scc_context_ctrl_sva chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .txn_valid(txn_valid), .txn_barrier(txn_barrier),
  .txn_barrier_sh(txn_barrier_sh), .txn_pass(txn_pass), .txn_stall(txn_stall), .txn_abort(txn_abort),
  .txn_blocked(txn_blocked), .fault_irq(fault_irq), .access_flag_fault(access_flag_fault),
  .guard_fault(guard_fault), .barrier_sh_out(barrier_sh_out));
